/* File: design/ufr_pkg.sv */
package ufr_pkg;
  // Register byte addresses.
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_STAT = 5'h04;
  localparam logic [4:0] A_MASK = 5'h08;
  localparam logic [4:0] A_RXBUF = 5'h0C;
  localparam logic [4:0] A_TXDATA = 5'h10;
  localparam logic [4:0] A_DIV = 5'h14;
  // Control register field positions.
  localparam int C_TXP = 0;
  localparam int C_RXP = 1;
  localparam int C_CLEN = 2;
  localparam int C_SLEN = 3;
  localparam int C_PM = 4;
  localparam int C_RXACT = 8;
  localparam int C_TXBSY = 9;
  // Status and mask bit positions.
  localparam int S_RXD = 0;
  localparam int S_PER = 1;
  localparam int S_FER = 2;
  localparam int S_TXD = 3;
  localparam int NSTAT = 4;
  // Bit period divider.
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_RST = 16'h0364;
  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
  // Parity modes.
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_ZERO = 2'h1;
  localparam logic [1:0] PM_ODD = 2'h2;
  localparam logic [1:0] PM_EVEN = 2'h3;
  // Character lengths.
  localparam logic [3:0] LEN7 = 4'h7;
  localparam logic [3:0] LEN8 = 4'h8;

  // Frame sequencer states shared by both directions.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100
  } ufr_state_t;

  // Number of data bits for the character-length select.
  function automatic logic [3:0] ufr_clen(input logic len8);
    return len8 ? LEN8 : LEN7;
  endfunction

  // Parity bit to send or expect; zero parity and no parity give 0.
  function automatic logic ufr_par(input logic [7:0] d, input logic len8, input logic [1:0] pm);
    logic p;
    p = (^d[6:0]) ^ (len8 & d[7]);
    case (pm)
      PM_ODD: return ~p;
      PM_EVEN: return p;
      default: return 1'b0;
    endcase
  endfunction
endpackage

/* File: design/ufr_top.sv */
// Operation
// - Frames carry 7 data bits when char_len_sel is 0, 8 when 1.
// - Transmit appends one stop bit when stop_len_sel is 0, two when 1.
// - Zero parity mode never checks parity nor sets parity_err_flag.
// - With receive_permit low, no start detection, shifting, or buffer update.
// - With receive_permit high, start bit begins shifting; full frame loads rx_holding_buffer.
// - rx_done_irq pulses in the same cycle as the buffer load.
//
// Implementation choices: the register offsets and the strobed register port.
module ufr_top #(
  parameter logic [15:0] DIV_RESET = ufr_pkg::DIV_RST
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Register port.
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Serial pins.
  input wire logic rxd,
  output logic txd,
  // Interrupts and received data.
  output logic irq,
  output logic rx_done_irq,
  output logic [7:0] rx_holding_buffer
);
  typedef struct packed {
    logic txp;
    logic rxp;
    logic clen8;
    logic slen2;
    logic [1:0] pm;
    logic [15:0] div;
    logic [ufr_pkg::NSTAT-1:0] stat;
    logic [ufr_pkg::NSTAT-1:0] mask;
    logic [7:0] rxbuf;
    logic [7:0] txdat;
    logic go;
    logic [31:0] rdata;
    ufr_pkg::ufr_state_t st;
    logic [15:0] rcnt;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rpar;
    logic s1;
    logic s2;
    logic prev;
    logic rx_done;
  } ufr_top_st_t;

  ufr_top_st_t q;
  ufr_top_st_t n;
  ufr_tx_if tif();
  logic [7:0] rx_al;
  logic [19:0] h_dcyc;

  ufr_tx u_tx (
    .clock(clock),
    .rstn(rstn),
    .t(tif.tx),
    .txd(txd)
  );

  // Drive the transmitter from the stored settings.
  assign tif.go = q.go;
  assign tif.data = q.txdat;
  assign tif.len8 = q.clen8;
  assign tif.stop2 = q.slen2;
  assign tif.pmode = q.pm;
  assign tif.div = q.div;

  // Register access, receive sequencer and event flags.
  always_comb begin
    n = q;
    n.go = 1'b0;
    n.rx_done = 1'b0;
    n.rdata = 32'h00000000;
    rx_al = q.clen8 ? q.rsh : {1'b0, q.rsh[7:1]};
    n.s1 = rxd;
    n.s2 = q.s1;
    n.prev = q.s2;
    // Reads answer one cycle later; unmapped addresses read zero.
    if (reg_rd) begin
      case (reg_addr)
        ufr_pkg::A_CTRL: begin
          n.rdata[ufr_pkg::C_TXP] = q.txp;
          n.rdata[ufr_pkg::C_RXP] = q.rxp;
          n.rdata[ufr_pkg::C_CLEN] = q.clen8;
          n.rdata[ufr_pkg::C_SLEN] = q.slen2;
          n.rdata[ufr_pkg::C_PM +: 2] = q.pm;
          n.rdata[ufr_pkg::C_RXACT] = (q.st != ufr_pkg::ST_IDLE);
          n.rdata[ufr_pkg::C_TXBSY] = tif.busy;
        end
        ufr_pkg::A_STAT: n.rdata[ufr_pkg::NSTAT-1:0] = q.stat;
        ufr_pkg::A_MASK: n.rdata[ufr_pkg::NSTAT-1:0] = q.mask;
        ufr_pkg::A_RXBUF: n.rdata[7:0] = q.rxbuf;
        ufr_pkg::A_TXDATA: n.rdata[7:0] = q.txdat;
        ufr_pkg::A_DIV: n.rdata[15:0] = q.div;
        default: n.rdata = 32'h00000000;
      endcase
    end
    // Writes; status bits clear on a written one.
    if (reg_wr) begin
      case (reg_addr)
        ufr_pkg::A_CTRL: begin
          n.txp = reg_wdata[ufr_pkg::C_TXP];
          n.rxp = reg_wdata[ufr_pkg::C_RXP];
          n.clen8 = reg_wdata[ufr_pkg::C_CLEN];
          n.slen2 = reg_wdata[ufr_pkg::C_SLEN];
          n.pm = reg_wdata[ufr_pkg::C_PM +: 2];
        end
        ufr_pkg::A_STAT: n.stat = q.stat & ~reg_wdata[ufr_pkg::NSTAT-1:0];
        ufr_pkg::A_MASK: n.mask = reg_wdata[ufr_pkg::NSTAT-1:0];
        ufr_pkg::A_TXDATA: begin
          n.txdat = reg_wdata[7:0];
          n.go = q.txp && !tif.busy && !q.go;
        end
        ufr_pkg::A_DIV: n.div = reg_wdata[15:0];
        default: n.go = 1'b0;
      endcase
    end
    if (tif.done) begin
      n.stat[ufr_pkg::S_TXD] = 1'b1;
    end
    // Receive sequencer; parked while reception is off.
    if (!q.rxp) begin
      n.st = ufr_pkg::ST_IDLE;
    end else if (q.st == ufr_pkg::ST_IDLE) begin
      if (q.prev && !q.s2) begin
        n.st = ufr_pkg::ST_START;
        n.rcnt = {1'b0, q.div[15:1]};
      end
    end else if (q.rcnt != 16'h0000) begin
      n.rcnt = q.rcnt - ufr_pkg::DIV_ONE;
    end else begin
      n.rcnt = q.div - ufr_pkg::DIV_ONE;
      case (q.st)
        ufr_pkg::ST_START: begin
          n.rbit = 4'h0;
          n.st = q.s2 ? ufr_pkg::ST_IDLE : ufr_pkg::ST_DATA;
        end
        ufr_pkg::ST_DATA: begin
          n.rsh = {q.s2, q.rsh[7:1]};
          n.rbit = q.rbit + 4'h1;
          if (q.rbit == ufr_pkg::ufr_clen(q.clen8) - 4'h1) begin
            n.st = (q.pm == ufr_pkg::PM_NONE) ? ufr_pkg::ST_STOP : ufr_pkg::ST_PAR;
          end
        end
        ufr_pkg::ST_PAR: begin
          n.rpar = q.s2;
          n.st = ufr_pkg::ST_STOP;
        end
        ufr_pkg::ST_STOP: begin
          n.st = ufr_pkg::ST_IDLE;
          n.rxbuf = rx_al;
          n.rx_done = 1'b1;
          n.stat[ufr_pkg::S_RXD] = 1'b1;
          if (!q.s2) begin
            n.stat[ufr_pkg::S_FER] = 1'b1;
          end
          // Only odd and even parity are checked.
          if (q.pm[1] && q.rpar != ufr_pkg::ufr_par(rx_al, q.clen8, q.pm)) begin
            n.stat[ufr_pkg::S_PER] = 1'b1;
          end
        end
        default: n.st = ufr_pkg::ST_IDLE;
      endcase
    end
  end

  // State register; the line samplers start at the idle level.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.div <= DIV_RESET;
      q.s1 <= 1'b1;
      q.s2 <= 1'b1;
      q.prev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq = |(q.stat & q.mask);
  assign rx_done_irq = q.rx_done;
  assign rx_holding_buffer = q.rxbuf;

  // Counts cycles spent shifting data bits for the length check.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      h_dcyc <= 20'h00000;
    end else begin
      h_dcyc <= (q.st == ufr_pkg::ST_DATA) ? h_dcyc + 20'h00001 : 20'h00000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_fall;
    q.rxp && q.st == ufr_pkg::ST_IDLE && q.prev && !q.s2;
  endsequence

  sequence s_stop_end;
    q.rxp && q.st == ufr_pkg::ST_STOP && q.rcnt == 16'h0000;
  endsequence

  a_rx_len: assert property ((q.rxp && q.st == ufr_pkg::ST_DATA && n.st != ufr_pkg::ST_DATA) |->
    (h_dcyc + 20'h00001 == 20'(ufr_pkg::ufr_clen(q.clen8)) * 20'(q.div)))
    else $error("Received data phase length does not match the character length.");
  a_zero_par: assert property ((!q.pm[1] && !q.stat[ufr_pkg::S_PER] && !reg_wr) |=>
    !q.stat[ufr_pkg::S_PER])
    else $error("Parity error raised while parity is not checked.");
  a_rx_off: assert property (!q.rxp |=> ($stable(rx_holding_buffer) && !rx_done_irq &&
    q.st == ufr_pkg::ST_IDLE))
    else $error("Receiver active while reception is disabled.");
  a_rx_start: assert property (s_fall |=> q.st == ufr_pkg::ST_START)
    else $error("Start bit not detected.");
  a_rx_xfer: assert property (s_stop_end |=> (rx_done_irq && q.st == ufr_pkg::ST_IDLE &&
    rx_holding_buffer == $past(rx_al)))
    else $error("Completed frame not moved to the holding buffer.");
  a_irq_sync: assert property ($changed(rx_holding_buffer) |-> rx_done_irq)
    else $error("Holding buffer changed without a receive-complete request.");
  a_irq_once: assert property (rx_done_irq |=> !rx_done_irq ##0 $past(q.st, 2) == ufr_pkg::ST_STOP)
    else $error("Receive-complete request not a single pulse after a frame.");
endmodule

/* File: design/ufr_tx.sv */
module ufr_tx (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Link to the register side.
  ufr_tx_if.tx t,
  // Serial output.
  output logic txd
);
  typedef struct packed {
    ufr_pkg::ufr_state_t st;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic par;
    logic len8;
    logic stop2;
    logic [1:0] pm;
    logic txd;
    logic done;
  } ufr_tx_st_t;

  ufr_tx_st_t q;
  ufr_tx_st_t n;
  logic [19:0] h_hi;

  // Frame sequencer; data, length, stop and parity settings are latched at frame start, but the divider is read at every bit reload.
  always_comb begin
    n = q;
    n.done = 1'b0;
    if (q.st != ufr_pkg::ST_IDLE && q.cnt != 16'h0000) begin
      n.cnt = q.cnt - ufr_pkg::DIV_ONE;
    end else begin
      case (q.st)
        ufr_pkg::ST_IDLE: begin
          n.txd = 1'b1;
          if (t.go) begin
            n.sh = t.data;
            n.len8 = t.len8;
            n.stop2 = t.stop2;
            n.pm = t.pmode;
            n.par = ufr_pkg::ufr_par(t.data, t.len8, t.pmode);
            n.txd = 1'b0;
            n.cnt = t.div - ufr_pkg::DIV_ONE;
            n.st = ufr_pkg::ST_START;
          end
        end
        ufr_pkg::ST_START: begin
          n.txd = q.sh[0];
          n.sh = {1'b0, q.sh[7:1]};
          n.bitn = 4'h0;
          n.cnt = t.div - ufr_pkg::DIV_ONE;
          n.st = ufr_pkg::ST_DATA;
        end
        ufr_pkg::ST_DATA: begin
          n.cnt = t.div - ufr_pkg::DIV_ONE;
          if (q.bitn == ufr_pkg::ufr_clen(q.len8) - 4'h1) begin
            n.bitn = 4'h0;
            n.txd = (q.pm == ufr_pkg::PM_NONE) ? 1'b1 : q.par;
            n.st = (q.pm == ufr_pkg::PM_NONE) ? ufr_pkg::ST_STOP : ufr_pkg::ST_PAR;
          end else begin
            n.txd = q.sh[0];
            n.sh = {1'b0, q.sh[7:1]};
            n.bitn = q.bitn + 4'h1;
          end
        end
        ufr_pkg::ST_PAR: begin
          n.txd = 1'b1;
          n.bitn = 4'h0;
          n.cnt = t.div - ufr_pkg::DIV_ONE;
          n.st = ufr_pkg::ST_STOP;
        end
        ufr_pkg::ST_STOP: begin
          if (q.stop2 && q.bitn == 4'h0) begin
            n.bitn = 4'h1;
            n.cnt = t.div - ufr_pkg::DIV_ONE;
          end else begin
            n.st = ufr_pkg::ST_IDLE;
            n.done = 1'b1;
          end
        end
        default: n.st = ufr_pkg::ST_IDLE;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.txd <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign txd = q.txd;
  assign t.busy = (q.st != ufr_pkg::ST_IDLE);
  assign t.done = q.done;

  // Counts cycles spent in the stop phase for the check below.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      h_hi <= 20'h00000;
    end else begin
      h_hi <= (q.st == ufr_pkg::ST_STOP) ? h_hi + 20'h00001 : 20'h00000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_stop_len: assert property ((q.st == ufr_pkg::ST_STOP && n.st == ufr_pkg::ST_IDLE) |->
    (h_hi + 20'h00001 == 20'(t.div) * (q.stop2 ? 20'h00002 : 20'h00001) && q.txd))
    else $error("Stop phase length does not match the stop-length select.");
endmodule

/* File: design/ufr_tx_if.sv */
interface ufr_tx_if;
  logic go;
  logic [7:0] data;
  logic len8;
  logic stop2;
  logic [1:0] pmode;
  logic [15:0] div;
  logic busy;
  logic done;
  modport ctl(output go, data, len8, stop2, pmode, div, input busy, done);
  modport tx(input go, data, len8, stop2, pmode, div, output busy, done);
endinterface

/* File: testbench/tb_uart_frame_format_and_receive.sv */
// Self-checking bench for the frame format and receive path.
module tb_uart_frame_format_and_receive;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int P = 8;
  logic clock, rstn, reg_wr, reg_rd, rxd, txd, irq, rx_done_irq;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [7:0] rx_holding_buffer, d, old, sh;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int pulses = 0;
  int p0, t0, k;
  int len[2];
  int q[$];

  ufr_top u_ufr_top (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd), .irq(irq),
    .rx_done_irq(rx_done_irq), .rx_holding_buffer(rx_holding_buffer));
  ufr_peer #(.P(P)) u_ufr_peer (.clock(clock), .rxd(rxd));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compares one observed value with the expected one.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle register write, then an idle cycle.
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  // One-cycle register read; data is taken in the cycle after the strobe.
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clock);
  endtask

  // Sends one frame and lets the receiver finish it.
  task automatic rx_frame(input logic [7:0] dd, input int nb, input bit pe, input logic pb);
    u_ufr_peer.send(dd, nb, pe, pb);
    repeat (2 * P) @(posedge clock);
  endtask

  // Every completion pulse is matched against the model's next character.
  // Sampling on the falling edge sees settled outputs and keeps the cycle count race free.
  always @(negedge clock) begin
    cycles++;
    if (rx_done_irq === 1'b1) begin
      pulses++;
      if (q.size() > 0) check("rx buffer", {24'h0, rx_holding_buffer}, q.pop_front());
      else check("unexpected rx pulse", 32'h1, 32'h0);
    end
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // Main sequence.
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    void'($urandom(32'h7F7A));
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(ufr_pkg::A_CTRL, rv);
    check("ctrl reset", rv, 32'h0);
    rd(5'h1C, rv);
    check("unmapped read", rv, 32'h0);
    wr(ufr_pkg::A_DIV, P);
    wr(ufr_pkg::A_MASK, 32'h0000000F);
    // Both character lengths; bit 7 set shows the 7-bit truncation.
    for (int L = 0; L < 2; L++) begin
      wr(ufr_pkg::A_CTRL, 32'h0);
      wr(ufr_pkg::A_CTRL, (1 << ufr_pkg::C_RXP) | (L << ufr_pkg::C_CLEN));
      d = 8'($urandom) | 8'h80;
      q.push_back(L ? d : {1'b0, d[6:0]});
      rx_frame(d, L ? 8 : 7, 1'b0, 1'b0);
      rd(ufr_pkg::A_STAT, rv);
      check("rx done status", rv, 32'h1 << ufr_pkg::S_RXD);
      check("irq raised", irq, 1);
      wr(ufr_pkg::A_STAT, 32'h0000000F);
      check("irq cleared", irq, 0);
    end
    // Zero parity with a wrong bit, even parity with a wrong bit, odd parity with a right bit.
    for (int m = 0; m < 3; m++) begin
      wr(ufr_pkg::A_CTRL, 32'h0);
      wr(ufr_pkg::A_CTRL, 32'h6 | ((m == 0 ? ufr_pkg::PM_ZERO : m == 1 ? ufr_pkg::PM_EVEN : ufr_pkg::PM_ODD)
        << ufr_pkg::C_PM));
      d = 8'($urandom);
      q.push_back(d);
      rx_frame(d, 8, 1'b1, m ? ~(^d) : 1'b1);
      rd(ufr_pkg::A_STAT, rv);
      check("parity flag", rv[ufr_pkg::S_PER], m == 1);
      wr(ufr_pkg::A_STAT, 32'h0000000F);
    end
    // Reception disabled: no pulse and the buffer is kept.
    wr(ufr_pkg::A_CTRL, 32'h0);
    old = rx_holding_buffer;
    p0 = pulses;
    rx_frame(8'($urandom), 8, 1'b0, 1'b0);
    check("no rx while off", pulses, p0);
    check("buffer kept", rx_holding_buffer, old);
    check("model drained", q.size(), 0);
    // Transmit with one and with two stop bits; only tx done is unmasked.
    wr(ufr_pkg::A_MASK, 32'h8);
    for (int s = 0; s < 2; s++) begin
      wr(ufr_pkg::A_CTRL, 32'h0);
      wr(ufr_pkg::A_CTRL, 32'h5 | (s << ufr_pkg::C_SLEN));
      wr(ufr_pkg::A_STAT, 32'h0000000F);
      d = 8'($urandom);
      wr(ufr_pkg::A_TXDATA, d);
      for (k = 0; k < 50 && txd !== 1'b0; k++) @(posedge clock);
      t0 = cycles;
      repeat (P / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (P) @(posedge clock);
        sh[i] = txd;
      end
      check("tx data", sh, d);
      for (k = 0; k < 100 && irq !== 1'b1; k++) @(posedge clock);
      len[s] = cycles - t0;
    end
    check("second stop bit", len[1] - len[0], P);
    test_done();
  end
endmodule

/* File: testbench/ufr_peer.sv */
// Far-side serial transmitter that drives the receive pin of the block.
module ufr_peer #(
  parameter int P = 8
) (
  // Clock.
  input wire logic clock,
  // Serial line towards the block.
  output logic rxd
);
  timeunit 1ns;
  timeprecision 100ps;

  // The line idles high between frames.
  initial rxd = 1'b1;

  // Holds one bit on the line for a full bit period.
  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (P) @(posedge clock);
  endtask

  // Sends start, data LSB first, optional parity, then one stop bit.
  task automatic send(input logic [7:0] d, input int nb, input bit pe, input logic pb);
    bit_out(1'b0);
    for (int i = 0; i < nb; i++) bit_out(d[i]);
    if (pe) bit_out(pb);
    bit_out(1'b1);
  endtask
endmodule
